// *** dv/sms_mech_model.sv ***
// Behavioural wheel mechanism with coarse and fine sensors
module sms_mech_model (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       clr_i,
  input  wire logic       busy_req_i,
  input  wire logic [7:0] coarse_from_i,
  input  wire logic [7:0] fine_every_i,
  input  wire logic [7:0] cmd_i,
  input  wire logic       cmd_wr_i,
  output logic            busy_o,
  output logic [17:0]     word_o,
  output logic            fine_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  pos;
  logic [3:0]  wheel_q;
  logic [16:0] noise;
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pos <= 8'h00;
      wheel_q <= 4'h0;
      noise <= 17'h00000;
    end else begin
      noise <= noise + 17'h0AAAB;
      if (cmd_wr_i) wheel_q <= cmd_i[7:4];
      if (clr_i) pos <= 8'h00;
      else if (cmd_wr_i && cmd_i[7:4] != wheel_q) pos <= pos + 8'h01;
    end
  end
  assign busy_o = busy_req_i;
  // Unused readback bits churn so stale values cannot pass
  assign word_o = {noise, pos >= coarse_from_i};
  assign fine_o = pos != 8'h00 && pos % fine_every_i == 8'h00;
endmodule // sms_mech_model

// *** dv/sms_sequencer_assertions.sv ***
// Port checker for the stepper motion sequencer
module sms_checker (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        clk_en_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        bus_busy_i,
  input wire logic [17:0] coarse_word_i,
  input wire logic        fine_sensor_i,
  input wire logic [7:0]  mech_cmd_o,
  input wire logic        mech_cmd_wr_o,
  input wire logic        move_done_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Long busy spans: covers settle delay plus input sync
  logic [3:0] busy_n;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) busy_n <= 4'h0;
    else if (!bus_busy_i) busy_n <= 4'h0;
    else if (busy_n != 4'hF) busy_n <= busy_n + 4'h1;
  end
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read answer");
  a_cmd_cause: assert property ($changed(mech_cmd_o) |-> mech_cmd_wr_o)
    else $error("command word changed without issue pulse");
  a_wr_pulse: assert property (mech_cmd_wr_o |=> !mech_cmd_wr_o)
    else $error("issue pulse longer than one cycle");
  a_done_pulse: assert property (move_done_o |=> !move_done_o)
    else $error("done pulse longer than one cycle");
  a_one_motor: assert property (mech_cmd_wr_o |-> mech_cmd_o[7:4] == $past(mech_cmd_o[7:4])
    || mech_cmd_o[3:0] == $past(mech_cmd_o[3:0]))
    else $error("both motor nibbles changed at once");
  a_phase_hot: assert property ($changed(mech_cmd_o[7:4]) |-> $onehot(mech_cmd_o[7:4]))
    else $error("wheel phase pattern not a single coil");
  a_done_quiet: assert property (move_done_o |-> !mech_cmd_wr_o [*8])
    else $error("phase issued after termination");
  a_busy_skip: assert property (busy_n == 4'hF |-> !mech_cmd_wr_o)
    else $error("phase issued while command bus busy");
  c_done: cover property (move_done_o);
  c_mirror: cover property (mech_cmd_wr_o && $changed(mech_cmd_o[3:0]));
  c_busy: cover property (busy_n == 4'hF);
endmodule // sms_checker

bind sms_sequencer sms_checker i_sms_checker (.core_clk_i, .reset_i, .clk_en_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_busy_i, .coarse_word_i,
  .fine_sensor_i, .mech_cmd_o, .mech_cmd_wr_o, .move_done_o);

// *** dv/tb_top.sv ***
// Self-checking bench for the stepper motion sequencer
`include "sms_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic        bus_busy_i;
  logic [17:0] coarse_word_i;
  logic        fine_sensor_i;
  logic [7:0]  mech_cmd_o;
  logic        mech_cmd_wr_o;
  logic        move_done_o;
  logic        clr = 1'b0;
  logic        busy_req = 1'b0;
  logic [7:0]  coarse_from = 8'hFF;
  logic [7:0]  fine_every = 8'h03;
  logic [15:0] rv;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_wr_all = 0;
  int          wr_base = 0;
  int          n_wr;
  int          k;
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (mech_cmd_wr_o === 1'b1) n_wr_all <= n_wr_all + 1;
  // Issues since the last start, one driver per counter
  assign n_wr = n_wr_all - wr_base;
  // Short tick base keeps every move to a few thousand cycles
  sms_sequencer #(.TICK_BASE(32'h00008000)) i_sms_sequencer (.core_clk_i, .reset_i,
    .clk_en_i(1'b1), .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .bus_busy_i, .coarse_word_i, .fine_sensor_i, .mech_cmd_o, .mech_cmd_wr_o, .move_done_o);
  sms_mech_model i_sms_mech_model (.core_clk_i, .reset_i, .clr_i(clr), .busy_req_i(busy_req),
    .coarse_from_i(coarse_from), .fine_every_i(fine_every), .cmd_i(mech_cmd_o),
    .cmd_wr_i(mech_cmd_wr_o), .busy_o(bus_busy_i), .word_o(coarse_word_i),
    .fine_o(fine_sensor_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  function automatic logic [15:0] cw(input logic [2:0] m, input logic [5:0] f);
    return {5'h00, m, 2'h0, f | 6'h04};
  endfunction
  task automatic setup(input logic [7:0] cf);
    coarse_from <= cf;
    clr <= 1'b1;
    @(posedge core_clk_i);
    clr <= 1'b0;
  endtask
  task automatic start(input logic [15:0] c, input logic [15:0] s);
    wr(`SMS_ADDR_STEPS, s);
    wr(`SMS_ADDR_RATE, 16'h0100);
    wr_base = n_wr_all;
    wr(`SMS_ADDR_CTRL, c | 16'h0001);
  endtask
  task automatic wait_done;
    for (int t = 0; t < 40000 && move_done_o !== 1'b1; t++) @(negedge core_clk_i);
    check({15'h0000, move_done_o}, 16'h0001);
  endtask
  task automatic status(input logic [15:0] exp);
    rd(`SMS_ADDR_STATUS, rv);
    check(rv & 16'h0003, exp);
  endtask
  task automatic print_verdict;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(20 * 90000);
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    status(16'h0000);
    rd(4'hF, rv);
    check(rv, 16'h0000);
    start(cw(`SMS_MODE_STEPS, 6'h00), 16'h0003);
    wait_done;
    check(n_wr[15:0], 16'h0003);
    status(16'h0001);
    check(rv & 16'h00C0, 16'h00C0);
    rd(`SMS_ADDR_POS, rv);
    check(rv, 16'h0003);
    check({12'h000, mech_cmd_o[7:4]}, 16'h0008);
    wr(`SMS_ADDR_PHASE, 16'h0000);
    rd(`SMS_ADDR_PHASE, rv);
    check(rv, 16'h0008);
    start(cw(`SMS_MODE_MIR_POS, 6'h08), 16'h0002);
    wait_done;
    check(n_wr[15:0], 16'h0002);
    rd(`SMS_ADDR_PULSES, rv);
    check(rv, 16'h0002);
    rd(`SMS_ADDR_CMDWORD, rv);
    check({8'h00, rv[15:8]}, 16'h0002);
    check({12'h000, rv[7:4]}, 16'h0008);
    start(cw(`SMS_MODE_MIR_NEG, 6'h18), 16'h0001);
    wait_done;
    rd(`SMS_ADDR_CMDWORD, rv);
    check({8'h00, rv[15:8]}, 16'h0001);
    start(cw(`SMS_MODE_MIR_POS, 6'h28), 16'h0000);
    wait_done;
    check({12'h000, mech_cmd_o[3:0]}, 16'h0001);
    check({15'h0000, n_wr >= 31 && n_wr <= 35}, 16'h0001);
    rd(`SMS_ADDR_RATE, rv);
    check(rv, 16'h02F0);
    start(cw(`SMS_MODE_MIR_NEG, 6'h38), 16'h0000);
    wait_done;
    check({12'h000, mech_cmd_o[3:0]}, 16'h0002);
    check({15'h0000, n_wr >= 31 && n_wr <= 35}, 16'h0001);
    wr(`SMS_ADDR_PHASE, 16'h0001);
    rd(`SMS_ADDR_PHASE, rv);
    check(rv, 16'h0002);
    setup(8'h05);
    start(cw(`SMS_MODE_COARSE, 6'h00), 16'h0014);
    wait_done;
    status(16'h0001);
    check(rv & 16'h0004, 16'h0004);
    setup(8'hFF);
    start(cw(`SMS_MODE_COARSE, 6'h00), 16'h0003);
    wait_done;
    status(16'h0002);
    check(rv & 16'h0004, 16'h0000);
    setup(8'hFF);
    start(cw(`SMS_MODE_FINE, 6'h00), 16'h0002);
    wait_done;
    rd(`SMS_ADDR_FINE, rv);
    check(rv, 16'h0002);
    status(16'h0001);
    check(rv & 16'h0008, 16'h0008);
    setup(8'h05);
    start(cw(`SMS_MODE_DATUM, 6'h00), 16'h0014);
    wait_done;
    status(16'h0001);
    rd(`SMS_ADDR_POS, rv);
    check(rv, 16'h0000);
    rd(`SMS_ADDR_RATE, rv);
    check(rv, 16'h0040);
    // Ticks while not in use must be ignored
    start(16'h0000, 16'h0003);
    repeat (400) @(negedge core_clk_i);
    check(n_wr[15:0], 16'h0000);
    wr(`SMS_ADDR_CTRL, 16'h0002);
    busy_req <= 1'b1;
    start(cw(`SMS_MODE_STEPS, 6'h00), 16'h0003);
    repeat (400) @(negedge core_clk_i);
    check(n_wr[15:0], 16'h0000);
    busy_req <= 1'b0;
    wait_done;
    check(n_wr[15:0], 16'h0003);
    start(cw(`SMS_MODE_STEPS, 6'h00), 16'h0064);
    for (int t = 0; t < 2000 && n_wr < 2; t++) @(negedge core_clk_i);
    wr(`SMS_ADDR_CTRL, 16'h0006);
    k = n_wr;
    repeat (600) @(negedge core_clk_i);
    check(n_wr[15:0], k[15:0]);
    print_verdict;
  end
endmodule // tb_top

// *** hdl/sms_phase_mem.v ***
// Small memory of retained non-zero phase patterns, registered read
module sms_phase_mem #(
  parameter DEPTH = 2,
  parameter WIDTH = 4
) (
  input  wire             core_clk_i,
  input  wire             reset_i,
  input  wire             clk_en_i,
  input  wire             wr_en_i,
  input  wire             wr_addr_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire             rd_addr_i,
  output reg  [WIDTH-1:0] rd_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_word
      always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          mem[g] <= {WIDTH{1'b0}};
        end else if (clk_en_i && wr_en_i && (wr_addr_i == g)) begin
          mem[g] <= wr_data_i;
        end
      end
    end
  endgenerate
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= {WIDTH{1'b0}};
    end else if (clk_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // sms_phase_mem

// *** hdl/sms_regs.vh ***
// Constants for the stepper motion sequencer
`ifndef SMS_REGS_VH
`define SMS_REGS_VH
`define SMS_ADDR_CTRL      4'h0
`define SMS_ADDR_STEPS     4'h1
`define SMS_ADDR_RATE      4'h2
`define SMS_ADDR_STATUS    4'h3
`define SMS_ADDR_PHASE     4'h4
`define SMS_ADDR_POS       4'h5
`define SMS_ADDR_PULSES    4'h6
`define SMS_ADDR_FINE      4'h7
`define SMS_ADDR_CMDWORD   4'h8
`define SMS_CTRL_START     0
`define SMS_CTRL_STOP      1
`define SMS_CTRL_INUSE     2
`define SMS_CTRL_MIRROR    3
`define SMS_CTRL_DIRNEG    4
`define SMS_CTRL_LIMIT     5
`define SMS_CTRL_MODE_LO   8
`define SMS_CTRL_MODE_HI   10
`define SMS_MODE_STEPS     3'h0
`define SMS_MODE_COARSE    3'h1
`define SMS_MODE_FINE      3'h2
`define SMS_MODE_DATUM     3'h3
`define SMS_MODE_MIR_POS   3'h4
`define SMS_MODE_MIR_NEG   3'h5
`define SMS_PRO_ACCEL      2'h0
`define SMS_PRO_CRUISE     2'h1
`define SMS_PRO_DECEL      2'h2
`define SMS_PRO_FIXED      2'h3
`define SMS_LIMIT_STEPS    16'h001F
`define SMS_PHASE_MIR_1    4'h1
`define SMS_PHASE_MIR_2    4'h2
`define SMS_WHEEL_LO       4
`define SMS_PHASE_INIT     4'h1
`define SMS_RETRY_CYCLES   16'h0032
`define SMS_SETTLE_CYCLES  4'h4
`endif

// *** hdl/sms_sequencer.v ***
// Stepper motion sequencer for the wheel and mirror mechanisms
// Operation
// - Four-bit phase pattern, bit 0 is phase 1
// - Keep last non-zero phase per motor, readable
// - Status shows coarse sensor currently seen
// - Status shows fine sensor seen
// - Start marks first pulse, clears counters, schedules
// - Stop cancels pending tick
// - Busy command bus: skip tick, retry shortly
// - Process only in use; rearm timer first
// - Evaluate exit after settling, except first pulse
// - Step mode finishes at max; brake decelerates
// - Coarse mode finishes on sensor; overrun errors
// - Fine mode counts pulses; finish equal, error above
// - Datum finishes on both sensors, resets position
// - Datum rate very slow on coarse, else pull-in
// - Positive limit: 31 steps and phase 1
// - Negative limit: 31 steps and phase 2
// - First pulse skips exit, clears first flag
// - Finished or error terminates movement
// - Drive next phase, update positions, count pulse
// - Accelerate to max speed, then cruise
// - Decelerate to pull-in, then fixed speed
// - Wheel phases upper, mirror lower, shared word
// - Coarse status from one bit of readback
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "sms_regs.vh"
module sms_sequencer #(
  parameter [15:0] ACCEL_STEP  = 16'h0010,
  parameter [15:0] DECEL_STEP  = 16'h0010,
  parameter [15:0] MAX_RATE    = 16'h0400,
  parameter [15:0] PULLIN_RATE = 16'h0100,
  parameter [15:0] SLOW_RATE   = 16'h0040,
  parameter [15:0] BRAKE_STEPS = 16'h0020,
  parameter [31:0] TICK_BASE   = 32'h00100000,
  parameter        COARSE_BIT  = 0
) (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        clk_en_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  input  wire        bus_busy_i,
  input  wire [17:0] coarse_word_i,
  input  wire        fine_sensor_i,
  output reg  [7:0]  mech_cmd_o,
  output reg         mech_cmd_wr_o,
  output reg         move_done_o
);
  reg        busy_s1, busy_s2, fine_s1, fine_s2;
  reg [17:0] coarse_s1, coarse_s2;
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      fine_s1 <= 1'b0;
      fine_s2 <= 1'b0;
      coarse_s1 <= 18'h00000;
      coarse_s2 <= 18'h00000;
    end else if (clk_en_i) begin
      busy_s1 <= bus_busy_i;
      busy_s2 <= busy_s1;
      fine_s1 <= fine_sensor_i;
      fine_s2 <= fine_s1;
      coarse_s1 <= coarse_word_i;
      coarse_s2 <= coarse_s1;
    end
  end
  wire coarse_sensor_seen = coarse_s2[COARSE_BIT];
  wire fine_sensor_seen   = fine_s2;

  reg [15:0] ctrl, max_steps, init_rate, rate, pulses, fine_count, mirror_pos;
  reg [15:0] wheel_pos;
  reg [31:0] timer;
  reg        tick_armed, first_pulse, finished, error_flag, wheel_moving;
  reg        settle_wait;
  reg [3:0]  settle_cnt;
  reg [1:0]  profile;
  reg [3:0]  cur_phase;
  reg        rd_pend;
  reg [3:0]  rd_addr_q;
  wire [2:0] mode = ctrl[`SMS_CTRL_MODE_HI:`SMS_CTRL_MODE_LO];
  wire       sel_mirror = ctrl[`SMS_CTRL_MIRROR];
  wire       in_use = ctrl[`SMS_CTRL_INUSE];
  wire [3:0] mirror_phase = mech_cmd_o[`SMS_WHEEL_LO-1:0];

  // Rotate the one-hot/two-coil pattern; mirror reverses for negative travel
  function [3:0] next_phase_of;
    input [3:0] ph;
    input       rev;
    begin
      next_phase_of = rev ? {ph[0], ph[3:1]} : {ph[2:0], ph[3]};
    end
  endfunction
  function [31:0] interval_of;
    input [15:0] r;
    begin
      interval_of = (r == 16'h0000) ? TICK_BASE : TICK_BASE / {16'h0000, r};
    end
  endfunction

  wire wr_ctrl   = reg_wr_i && (reg_addr_i == `SMS_ADDR_CTRL);
  wire start_req = wr_ctrl && reg_wdata_i[`SMS_CTRL_START];
  wire stop_req  = wr_ctrl && reg_wdata_i[`SMS_CTRL_STOP];
  wire timer_hit = tick_armed && (timer == 32'h00000000);
  wire tick_go   = timer_hit && !busy_s2 && in_use;

  reg        next_finished, next_error;
  reg [15:0] next_fine;
  always @* begin
    next_finished = 1'b0;
    next_error    = 1'b0;
    next_fine     = fine_count;
    case (mode)
      `SMS_MODE_STEPS: begin
        next_finished = (pulses >= max_steps);
      end
      `SMS_MODE_COARSE: begin
        next_finished = coarse_sensor_seen;
        next_error    = !coarse_sensor_seen && (pulses > max_steps);
      end
      `SMS_MODE_FINE: begin
        if (fine_sensor_seen) begin
          next_fine = fine_count + 16'h0001;
        end
        next_finished = (next_fine == max_steps);
        next_error    = (next_fine > max_steps);
      end
      `SMS_MODE_DATUM: begin
        next_finished = coarse_sensor_seen && fine_sensor_seen;
        next_error    = !next_finished && (pulses > max_steps);
      end
      `SMS_MODE_MIR_POS: begin
        next_finished = ctrl[`SMS_CTRL_LIMIT] ?
          ((pulses >= `SMS_LIMIT_STEPS) && (mirror_phase == `SMS_PHASE_MIR_1)) :
          (pulses >= max_steps);
      end
      `SMS_MODE_MIR_NEG: begin
        next_finished = ctrl[`SMS_CTRL_LIMIT] ?
          ((pulses >= `SMS_LIMIT_STEPS) && (mirror_phase == `SMS_PHASE_MIR_2)) :
          (pulses >= max_steps);
      end
      default: begin
        next_finished = 1'b1;
      end
    endcase
  end

  // Each motor steps on from its own coils; an idle motor starts from phase 1
  wire [3:0] motor_phase = sel_mirror ? mirror_phase : mech_cmd_o[7:`SMS_WHEEL_LO];
  wire [3:0] base_phase  = (motor_phase == 4'h0) ? `SMS_PHASE_INIT : motor_phase;
  wire [3:0] phase_out = next_phase_of(base_phase, sel_mirror && ctrl[`SMS_CTRL_DIRNEG]);
  wire       mem_rd_sel = reg_wdata_i[0];
  wire [3:0] mem_rdata;
  reg        mem_rd_addr;
  sms_phase_mem #(.DEPTH(2), .WIDTH(4)) u_phase_mem (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .wr_en_i    (mech_cmd_wr_o && (cur_phase != 4'h0)),
    .wr_addr_i  (sel_mirror),
    .wr_data_i  (cur_phase),
    .rd_addr_i  (mem_rd_addr),
    .rd_data_o  (mem_rdata)
  );

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= 16'h0000;
      max_steps <= 16'h0000;
      init_rate <= 16'h0000;
      rate <= 16'h0000;
      pulses <= 16'h0000;
      fine_count <= 16'h0000;
      mirror_pos <= 16'h0000;
      wheel_pos <= 16'h0000;
      timer <= 32'h00000000;
      tick_armed <= 1'b0;
      first_pulse <= 1'b0;
      finished <= 1'b0;
      error_flag <= 1'b0;
      wheel_moving <= 1'b0;
      settle_wait <= 1'b0;
      settle_cnt <= 4'h0;
      profile <= `SMS_PRO_ACCEL;
      cur_phase <= `SMS_PHASE_INIT;
      mech_cmd_o <= 8'h00;
      mech_cmd_wr_o <= 1'b0;
      move_done_o <= 1'b0;
      mem_rd_addr <= 1'b0;
    end else if (clk_en_i) begin
      mech_cmd_wr_o <= 1'b0;
      move_done_o <= 1'b0;
      if (reg_wr_i && reg_addr_i == `SMS_ADDR_STEPS) begin
        max_steps <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `SMS_ADDR_RATE) begin
        init_rate <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `SMS_ADDR_POS) begin
        wheel_pos <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `SMS_ADDR_PHASE) begin
        mem_rd_addr <= mem_rd_sel;
      end
      if (wr_ctrl) begin
        ctrl <= reg_wdata_i & 16'h07FC;
      end
      if (tick_armed && timer != 32'h00000000) begin
        timer <= timer - 32'h00000001;
      end
      if (stop_req) begin
        tick_armed <= 1'b0;
        settle_wait <= 1'b0;
      end else if (start_req) begin
        first_pulse <= 1'b1;
        pulses <= 16'h0000;
        fine_count <= 16'h0000;
        finished <= 1'b0;
        error_flag <= 1'b0;
        rate <= init_rate;
        profile <= `SMS_PRO_ACCEL;
        tick_armed <= 1'b1;
        timer <= interval_of(init_rate);
      end else if (timer_hit && busy_s2) begin
        timer <= {16'h0000, `SMS_RETRY_CYCLES};
      end else if (timer_hit && !in_use) begin
        timer <= interval_of(rate);
      end else if (tick_go) begin
        timer <= interval_of(rate);
        settle_wait <= 1'b1;
        settle_cnt <= `SMS_SETTLE_CYCLES;
      end
      if (settle_wait && !stop_req) begin
        if (settle_cnt != 4'h0) begin
          settle_cnt <= settle_cnt - 4'h1;
        end else begin
          settle_wait <= 1'b0;
          if (first_pulse) begin
            first_pulse <= 1'b0;
            finished <= 1'b0;
            step_motor;
          end else if (next_finished || next_error) begin
            finished <= next_finished;
            error_flag <= next_error;
            fine_count <= next_fine;
            tick_armed <= 1'b0;
            wheel_moving <= 1'b0;
            move_done_o <= 1'b1;
            if (mode == `SMS_MODE_DATUM && next_finished) begin
              wheel_pos <= 16'h0000;
            end
          end else begin
            fine_count <= next_fine;
            step_motor;
          end
        end
      end
    end
  end

  task step_motor;
    begin
      cur_phase <= phase_out;
      mech_cmd_wr_o <= 1'b1;
      if (sel_mirror) begin
        mech_cmd_o <= {mech_cmd_o[7:`SMS_WHEEL_LO], phase_out};
        mirror_pos <= ctrl[`SMS_CTRL_DIRNEG] ? mirror_pos - 16'h0001
                                             : mirror_pos + 16'h0001;
      end else begin
        mech_cmd_o <= {phase_out, mech_cmd_o[`SMS_WHEEL_LO-1:0]};
        wheel_moving <= 1'b1;
        wheel_pos <= wheel_pos + 16'h0001;
      end
      pulses <= pulses + 16'h0001;
      if (mode == `SMS_MODE_DATUM) begin
        rate <= coarse_sensor_seen ? SLOW_RATE : PULLIN_RATE;
        profile <= `SMS_PRO_FIXED;
      end else begin
        case (profile)
          `SMS_PRO_ACCEL: begin
            if (mode == `SMS_MODE_STEPS && max_steps - pulses <= BRAKE_STEPS) begin
              profile <= `SMS_PRO_DECEL;
            end else if (rate + ACCEL_STEP >= MAX_RATE) begin
              rate <= MAX_RATE;
              profile <= `SMS_PRO_CRUISE;
            end else begin
              rate <= rate + ACCEL_STEP;
            end
          end
          `SMS_PRO_CRUISE: begin
            if (mode == `SMS_MODE_STEPS && max_steps - pulses <= BRAKE_STEPS) begin
              profile <= `SMS_PRO_DECEL;
            end
          end
          `SMS_PRO_DECEL: begin
            if (rate <= PULLIN_RATE + DECEL_STEP) begin
              rate <= PULLIN_RATE;
              profile <= `SMS_PRO_FIXED;
            end else begin
              rate <= rate - DECEL_STEP;
            end
          end
          default: begin
            rate <= rate;
          end
        endcase
      end
    end
  endtask

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_pend <= 1'b0;
      rd_addr_q <= 4'h0;
    end else if (clk_en_i) begin
      rd_pend <= reg_rd_i;
      rd_addr_q <= reg_addr_i;
    end
  end
  reg [15:0] rd_mux;
  always @* begin
    case (reg_addr_i)
      `SMS_ADDR_CTRL:    rd_mux = ctrl;
      `SMS_ADDR_STEPS:   rd_mux = max_steps;
      `SMS_ADDR_RATE:    rd_mux = rate;
      `SMS_ADDR_STATUS:  rd_mux = {8'h00, profile, tick_armed, wheel_moving,
                                   fine_sensor_seen, coarse_sensor_seen,
                                   error_flag, finished};
      `SMS_ADDR_PHASE:   rd_mux = {12'h000, mem_rdata};
      `SMS_ADDR_POS:     rd_mux = wheel_pos;
      `SMS_ADDR_PULSES:  rd_mux = pulses;
      `SMS_ADDR_FINE:    rd_mux = fine_count;
      `SMS_ADDR_CMDWORD: rd_mux = {mirror_pos[7:0], mech_cmd_o};
      default:           rd_mux = 16'h0000;
    endcase
  end
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
    end
  end
endmodule // sms_sequencer
